// ### logic/branch_unit_params.svh
// constants for the conditional branch unit
`ifndef BRANCH_UNIT_PARAMS_SVH
`define BRANCH_UNIT_PARAMS_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_ESCAPE 8'hA5
`define OP_BIT_SET_CLEAR 8'h10
`define OP_BIT_SET 8'h20
`define OP_BIT_CLEAR 8'h30
`define OP_BIT_EXT 8'hA9
`define OP_CARRY 8'h40
`define OP_NO_CARRY 8'h50
`define OP_EQUAL 8'h68
`define OP_NOT_EQUAL 8'h78
`define OP_GT_UNS 8'h38
`define OP_LE_UNS 8'h28
`define OP_ACC_NZ 8'h70
`define OP_GT_SGN 8'h18
`define OP_GE_SGN 8'h58
`define OP_LT_SGN 8'h48
`define OP_LE_SGN 8'h08
`define OP_ACC_Z 8'h60
`define OP_TABLE 8'h73
// ----------------------------------------
// extended bit-jump sub-opcode (upper nibble of the byte after the opcode)
// ----------------------------------------
`define SUB_SET_CLEAR 4'h1
`define SUB_SET 4'h2
`define SUB_CLEAR 4'h3
// ----------------------------------------
// lengths and reset value
// ----------------------------------------
`define LEN_SHORT 24'h000002
`define LEN_LONG 24'h000003
`define LEN_LONG_EXT 24'h000004
`define PC_RESET 24'h000000
`endif

// ### logic/branch_unit_pkg.sv
// types for the conditional branch unit
package branch_unit_pkg;
	// flags presented by the core
	typedef struct packed {
		logic carry_flag;
		logic overflow_flag;
		logic negative_flag;
		logic zero_flag;
	} flags_t;
	// fetched instruction, byte 0 first
	typedef struct packed {
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [7:0] byte4;
	} instr_t;
endpackage : branch_unit_pkg

// ### logic/conditional_branch_unit.sv
// conditional and indirect branch evaluation with program counter update
//
// Overview of operation
// - bit-set jump branches on one, bit kept
// - test-and-clear branches on one, clears bit
// - no write when tested bit already zero
// - port bits tested from output latch
// - three-byte bit jumps: pc+3 then displacement
// - two-byte jumps: pc+2 then displacement
// - 40h jumps on carry set
// - 50h jumps on carry clear, carry kept
// - 68h jumps on zero flag set
// - 78h jumps on zero flag clear
// - 38h jumps when zero and carry clear
// - 28h jumps when zero or carry set
// - 70h jumps on nonzero accumulator, unchanged
// - signed greater: zero clear, negative equals overflow
// - table jump adds accumulator to data pointer
// - 73h loads only low sixteen pc bits
// - bit-clear jump branches on zero, bit kept
// - binary mode needs A5 prefix for extended codes
`timescale 1ns/1ps
`include "branch_unit_params.svh"
module conditional_branch_unit #(
	parameter int PC_WIDTH = 24
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// instruction request
	input wire logic instr_valid,
	input wire branch_unit_pkg::instr_t instr,
	input wire logic source_mode,
	// operands
	input wire branch_unit_pkg::flags_t flags,
	input wire logic [7:0] accumulator_reg,
	input wire logic [15:0] data_pointer_word,
	input wire logic tested_bit_pin,
	input wire logic tested_bit_latch,
	input wire logic tested_bit_is_port,
	// results
	output logic [PC_WIDTH-1:0] pc,
	output logic done,
	output logic taken,
	output logic recognised,
	output logic bit_clear_write
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// sign-extended relative target from an advanced pc
	function automatic logic [PC_WIDTH-1:0] rel_target(
		input logic [PC_WIDTH-1:0] base,
		input logic [7:0] disp
	);
		logic [PC_WIDTH-1:0] ext;
		ext = {{(PC_WIDTH-8){disp[7]}}, disp};
		rel_target = base + ext;
	endfunction : rel_target

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic escaped; // prefix consumed
	logic [7:0] op; // opcode after optional prefix
	logic [7:0] op_b1; // byte after opcode
	logic [7:0] op_b2; // second byte after opcode
	logic [7:0] op_b3; // third byte after opcode
	logic bit_value; // value of the addressed bit
	logic next_taken;
	logic next_known;
	logic next_write;
	logic [PC_WIDTH-1:0] next_pc;
	logic [PC_WIDTH-1:0] adv; // pc past the instruction
	logic [15:0] table_sum; // accumulator plus data pointer
	logic [7:0] disp; // selected displacement
	logic ext_ok; // extended code legal in this mode
	logic table_jump;

	// prefix, operand byte selection
	always_comb begin
		escaped = (instr.byte0 == `OP_ESCAPE);
		op = escaped ? instr.byte1 : instr.byte0;
		op_b1 = escaped ? instr.byte2 : instr.byte1;
		op_b2 = escaped ? instr.byte3 : instr.byte2;
		op_b3 = escaped ? instr.byte4 : instr.byte3;
		// binary mode needs the prefix, source mode refuses it
		ext_ok = escaped ^ source_mode;
	end

	// port bits are read back from the latch, not the pin
	always_comb begin
		bit_value = tested_bit_is_port ? tested_bit_latch : tested_bit_pin;
	end

	// sum is 16 bits wide; carry out is dropped on purpose
	always_comb begin
		table_sum = data_pointer_word + {8'h00, accumulator_reg};
	end

	// condition evaluation and target selection
	always_comb begin
		next_taken = 1'b0;
		next_known = 1'b1;
		next_write = 1'b0;
		table_jump = 1'b0;
		adv = pc + `LEN_SHORT;
		disp = op_b1;
		unique case (op)
			`OP_BIT_SET_CLEAR, `OP_BIT_SET, `OP_BIT_CLEAR: begin
				// legacy bit address: never prefixed
				next_known = !escaped;
				adv = pc + `LEN_LONG;
				disp = op_b2;
				if (op == `OP_BIT_SET) begin
					next_taken = bit_value;
				end else if (op == `OP_BIT_CLEAR) begin
					next_taken = !bit_value;
				end else begin
					next_taken = bit_value;
					next_write = bit_value;
				end
			end
			`OP_BIT_EXT: begin
				// extended bit jump: sub-op, bit address, displacement
				next_known = ext_ok;
				adv = pc + (escaped ? `LEN_LONG_EXT : `LEN_LONG);
				disp = op_b3;
				unique case (op_b1[7:4])
					`SUB_SET: next_taken = bit_value;
					`SUB_CLEAR: next_taken = !bit_value;
					`SUB_SET_CLEAR: begin
						next_taken = bit_value;
						next_write = bit_value;
					end
					default: next_known = 1'b0;
				endcase
			end
			`OP_CARRY: next_taken = flags.carry_flag;
			`OP_NO_CARRY: next_taken = !flags.carry_flag;
			`OP_ACC_NZ: next_taken = |accumulator_reg;
			`OP_ACC_Z: next_taken = ~|accumulator_reg;
			`OP_EQUAL: next_taken = flags.zero_flag;
			`OP_NOT_EQUAL: next_taken = !flags.zero_flag;
			`OP_GT_UNS: begin
				next_taken = !flags.zero_flag && !flags.carry_flag;
			end
			`OP_LE_UNS: begin
				next_taken = flags.zero_flag || flags.carry_flag;
			end
			`OP_GT_SGN: begin
				next_taken = !flags.zero_flag &&
					(flags.negative_flag == flags.overflow_flag);
			end
			`OP_GE_SGN: begin
				next_taken = flags.negative_flag == flags.overflow_flag;
			end
			`OP_LT_SGN: begin
				next_taken = flags.negative_flag != flags.overflow_flag;
			end
			`OP_LE_SGN: begin
				next_taken = flags.zero_flag ||
					(flags.negative_flag != flags.overflow_flag);
			end
			`OP_TABLE: begin
				// table jump is a base-page code: no prefix
				next_known = !escaped;
				table_jump = 1'b1;
				next_taken = 1'b1;
			end
			default: next_known = 1'b0;
		endcase
		// extended flag jumps live behind the prefix in binary mode
		if (op == `OP_EQUAL || op == `OP_NOT_EQUAL || op == `OP_GT_UNS ||
			op == `OP_LE_UNS || op == `OP_GT_SGN || op == `OP_GE_SGN ||
			op == `OP_LT_SGN || op == `OP_LE_SGN) begin
			next_known = ext_ok;
		end else if (op == `OP_CARRY || op == `OP_NO_CARRY ||
			op == `OP_ACC_NZ || op == `OP_ACC_Z) begin
			next_known = !escaped;
		end
		// unknown codes neither branch nor write
		if (!next_known) begin
			next_taken = 1'b0;
			next_write = 1'b0;
		end
		if (table_jump) begin
			next_pc = {pc[PC_WIDTH-1:16], table_sum};
		end else if (next_taken) begin
			next_pc = rel_target(adv, disp);
		end else begin
			next_pc = adv;
		end
	end

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	// unknown codes leave pc alone so the core can route them elsewhere
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= `PC_RESET;
		end else if (instr_valid && next_known) begin
			pc <= next_pc;
		end
	end

	// ----------------------------------------
	// result strobes
	// ----------------------------------------
	// one-cycle pulses after each accepted instruction
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done <= 1'b0;
			taken <= 1'b0;
			recognised <= 1'b0;
			bit_clear_write <= 1'b0;
		end else begin
			done <= instr_valid;
			recognised <= instr_valid && next_known;
			taken <= instr_valid && next_taken;
			// clear only on a taken test-and-clear
			bit_clear_write <= instr_valid && next_write;
		end
	end
endmodule : conditional_branch_unit

// ### testbench/branch_unit_properties.sv
// checker with the timing properties of the branch unit
`timescale 1ns/1ps
`include "branch_unit_params.svh"
module branch_unit_properties #(
	parameter int PC_WIDTH = 24
) (
	// clock, reset and request
	input wire logic clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire branch_unit_pkg::instr_t instr,
	input wire logic source_mode,
	// operands
	input wire branch_unit_pkg::flags_t flags,
	input wire logic [7:0] accumulator_reg,
	input wire logic [15:0] data_pointer_word,
	input wire logic tested_bit_pin,
	input wire logic tested_bit_latch,
	input wire logic tested_bit_is_port,
	// results
	input wire logic [PC_WIDTH-1:0] pc,
	input wire logic taken,
	input wire logic recognised,
	input wire logic bit_clear_write
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// opcode of a request, zero when idle so no antecedent fires
	wire logic [7:0] op = instr_valid ? instr.byte0 : 8'h00;
	// port bits must be judged from the latch, not the pin
	wire logic tbit = tested_bit_is_port ? tested_bit_latch : tested_bit_pin;
	chk_carry_jump: assert property (
		op == `OP_CARRY |=> taken == $past(flags.carry_flag))
		else $error("carry jump decision wrong");
	chk_no_carry: assert property (
		op == `OP_NO_CARRY |=> taken == !$past(flags.carry_flag))
		else $error("no-carry jump decision wrong");
	chk_acc_nonzero: assert property (
		op == `OP_ACC_NZ |=> taken == ($past(accumulator_reg) != 8'h00))
		else $error("accumulator jump decision wrong");
	chk_short_pc: assert property (
		op == `OP_CARRY |=> pc == $past(pc) + PC_WIDTH'(2)
		+ (taken ? PC_WIDTH'($signed($past(instr.byte1))) : '0))
		else $error("short branch target wrong");
	chk_table_pc: assert property (
		op == `OP_TABLE |=> pc[15:0] == 16'($past(data_pointer_word)
		+ $past(accumulator_reg)) && $stable(pc[PC_WIDTH-1:16]))
		else $error("table jump target wrong");
	chk_clear_pulse: assert property (
		op == `OP_BIT_SET_CLEAR |=> bit_clear_write == $past(tbit))
		else $error("bit clear write wrong");
	chk_bit_kept: assert property (
		op == `OP_BIT_SET || op == `OP_BIT_CLEAR |=> !bit_clear_write)
		else $error("tested bit written");
	chk_prefix_needed: assert property (
		op == `OP_EQUAL && !source_mode |=> !recognised && $stable(pc))
		else $error("unprefixed code taken in binary mode");
	// main scenarios reached
	cover property (op == `OP_TABLE);
	cover property (bit_clear_write);
	cover property (taken && recognised);
endmodule : branch_unit_properties
bind conditional_branch_unit branch_unit_properties #(
	.PC_WIDTH(PC_WIDTH)) chk (.clk, .rst_b, .instr_valid, .instr,
	.source_mode, .flags, .accumulator_reg, .data_pointer_word,
	.tested_bit_pin, .tested_bit_latch, .tested_bit_is_port, .pc,
	.taken, .recognised, .bit_clear_write);

// ### testbench/conditional_branch_unit_bench.sv
// self-checking bench for the branch unit
`timescale 1ns/1ps
module conditional_branch_unit_bench;
	// ----------------------------------------
	// stimulus and results
	// ----------------------------------------
	logic clk, rst_b, instr_valid, source_mode;
	logic tested_bit_pin, tested_bit_latch, tested_bit_is_port;
	branch_unit_pkg::instr_t instr;
	branch_unit_pkg::flags_t flags;
	logic [7:0] accumulator_reg;
	logic [15:0] data_pointer_word;
	logic [23:0] pc, epc; // epc: expected program counter
	logic done, taken, recognised, bit_clear_write;
	int fails, tests_run;
	conditional_branch_unit DUT (.clk, .rst_b, .instr_valid, .instr,
		.source_mode, .flags, .accumulator_reg, .data_pointer_word,
		.tested_bit_pin, .tested_bit_latch, .tested_bit_is_port,
		.pc, .done, .taken, .recognised, .bit_clear_write);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	// c = {mode, carry, overflow, negative, zero, port, latch, pin}
	// len 0: refused, len -1: table jump, else advance before rel d
	task run(input logic [39:0] i, input logic [7:0] c,
		input logic [7:0] a, input logic tk, input logic wr,
		input int len, input logic [7:0] d);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= i;
		{source_mode, flags} <= c[7:3];
		{tested_bit_is_port, tested_bit_latch, tested_bit_pin} <= c[2:0];
		accumulator_reg <= a;
		@(posedge clk);
		instr_valid <= 1'b0;
		if (len < 0) epc[15:0] = data_pointer_word + 16'(a);
		else if (len > 0) epc = epc + 24'(len) + (tk ? 24'($signed(d)) : 24'h0);
		#1;
		check({done, recognised, taken, bit_clear_write}, {1'b1, len != 0, tk, wr});
		check(pc, epc);
		$display("step %h done", i[39:32]);
	endtask : run
	// ----------------------------------------
	// clock, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		end_sim();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_b, instr_valid, source_mode, flags, instr} = '0;
		{tested_bit_pin, tested_bit_latch, tested_bit_is_port} = '0;
		accumulator_reg = 8'h00;
		data_pointer_word = 16'h1234;
		{fails, tests_run, epc} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		run(40'h4080000000, 8'hC0, 8'h00, 1, 0, 2, 8'h80);
		run(40'h4010000000, 8'h80, 8'h00, 0, 0, 2, 8'h10);
		run(40'h5010000000, 8'h80, 8'h00, 1, 0, 2, 8'h10);
		run(40'h5010000000, 8'hC0, 8'h00, 0, 0, 2, 8'h10);
		run(40'h6805000000, 8'h88, 8'h00, 1, 0, 2, 8'h05);
		run(40'h7805000000, 8'h88, 8'h00, 0, 0, 2, 8'h05);
		run(40'h7805000000, 8'h80, 8'h00, 1, 0, 2, 8'h05);
		run(40'h3805000000, 8'h80, 8'h00, 1, 0, 2, 8'h05);
		run(40'h3805000000, 8'hC0, 8'h00, 0, 0, 2, 8'h05);
		run(40'h2805000000, 8'hC0, 8'h00, 1, 0, 2, 8'h05);
		run(40'h2805000000, 8'h80, 8'h00, 0, 0, 2, 8'h05);
		run(40'h1805000000, 8'h80, 8'h00, 1, 0, 2, 8'h05);
		run(40'h1805000000, 8'hA0, 8'h00, 0, 0, 2, 8'h05);
		run(40'h7005000000, 8'h80, 8'h00, 0, 0, 2, 8'h05);
		run(40'h7005000000, 8'h80, 8'h01, 1, 0, 2, 8'h05);
		run(40'h2000F00000, 8'h81, 8'h00, 1, 0, 3, 8'hF0);
		run(40'h2000F00000, 8'h80, 8'h00, 0, 0, 3, 8'hF0);
		run(40'h3000070000, 8'h80, 8'h00, 1, 0, 3, 8'h07);
		run(40'h1000070000, 8'h81, 8'h00, 1, 1, 3, 8'h07);
		run(40'h1000070000, 8'h80, 8'h00, 0, 0, 3, 8'h07);
		run(40'h1000070000, 8'h86, 8'h00, 1, 1, 3, 8'h07);
		run(40'h6805000000, 8'h08, 8'h00, 0, 0, 0, 8'h05);
		run(40'hA568050000, 8'h08, 8'h00, 1, 0, 2, 8'h05);
		run(40'h5805000000, 8'hA0, 8'h00, 0, 0, 2, 8'h05);
		run(40'h4805000000, 8'hA0, 8'h00, 1, 0, 2, 8'h05);
		run(40'h0805000000, 8'h88, 8'h00, 1, 0, 2, 8'h05);
		run(40'h6005000000, 8'h80, 8'h00, 1, 0, 2, 8'h05);
		run(40'hA92000F000, 8'h81, 8'h00, 1, 0, 3, 8'hF0);
		run(40'hA5A9100007, 8'h01, 8'h00, 1, 1, 4, 8'h07);
		run(40'h7300000000, 8'h80, 8'hF0, 1, 0, -1, 8'h00);
		end_sim();
	end
endmodule : conditional_branch_unit_bench
